// ---- design/period_timer_defines.svh ----
`ifndef PERIOD_TIMER_DEFINES_SVH
`define PERIOD_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------------
`define CTRL_RUN_BIT 15
`define CTRL_IDLE_STOP_BIT 13
`define CTRL_GATE_BIT 6
`define CTRL_PRESCALE_HI 5
`define CTRL_PRESCALE_LO 4
`define CTRL_SYNC_BIT 2
`define CTRL_SOURCE_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RESET 16'h0000
`define PERIOD_RESET 16'hFFFF
`define COUNT_RESET 16'h0000

// ----------------------------------------------------------------------
// Prescale terminal counts (divide minus one)
// ----------------------------------------------------------------------
`define PRESCALE_TC_1 8'h00
`define PRESCALE_TC_8 8'h07
`define PRESCALE_TC_64 8'h3F
`define PRESCALE_TC_256 8'hFF

`endif

// ---- design/period_timer_pkg.sv ----
package period_timer_pkg;

  typedef enum logic [1:0] {
    PRESCALE_1 = 2'h0,
    PRESCALE_8 = 2'h1,
    PRESCALE_64 = 2'h2,
    PRESCALE_256 = 2'h3
  } prescale_t;

  typedef struct packed {
    logic counter_run_enable;
    logic idle_stop_select;
    logic gate_accumulate_enable;
    prescale_t prescale_select;
    logic external_sync_select;
    logic clock_source_select;
  } ctrl_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0] presc;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic match_evt;
    logic gate_evt;
    logic flag;
  } state_t;

endpackage : period_timer_pkg

// ---- design/period_timer_16bit.sv ----
// What this block does
// [RL1] Sixteen-bit interval timer or counter
// [RL2] Timer mode counts cycles, wraps at period
// [RL3] Idle halts counting when idle-stop set
// [RL4] Synchronous counter syncs pin, counts rising edges
// [RL5] Asynchronous counter counts pin edges, wraps at period
// [RL6] Asynchronous counter stops in idle if idle-stop
// [RL7] Gated mode counts cycles while gate high
// [RL8] Software sets run, internal source with gate
// [RL9] Event on match and gate falling edge
// [RL10] Prescale divides by 1, 8, 64, 256
// [RL11] Prescaler clears on count write, stop, reset
// [RL12] Flag set on event, cleared by software
// [RL13] Sleep counts only enabled, external, asynchronous
// [RL14] Match zeroes next count, pulses event
// [RL15] Reset clears configuration, counter stopped
`include "period_timer_defines.svh"

module period_timer_16bit #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control word write
  input wire logic [15:0] timer_control_word,
  input wire logic control_write,
  // Count and period writes
  input wire logic [15:0] count_write_data,
  input wire logic count_write,
  input wire logic [15:0] period_write_data,
  input wire logic period_write,
  // Software flag clear
  input wire logic flag_clear,
  // CPU power state
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // External clock or gate
  input wire logic external_clock_gate_pin,
  // Status
  output logic [15:0] count_value,
  output logic [15:0] period_match_value,
  output logic [15:0] control_readback,
  output logic match_event,
  output logic gate_end_event,
  output logic period_interrupt_flag
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // [RL1] Fixed width
  if (COUNT_WIDTH != 16) begin : g_width_check
    $error("period_timer_16bit supports only a 16-bit count");
  end

  // Prescale field must stay two bits to fit prescale_t
  if (`CTRL_PRESCALE_HI - `CTRL_PRESCALE_LO != 1) begin : g_field_check
    $error("period_timer_16bit needs a two-bit prescale field");
  end

  period_timer_pkg::state_t s_q;
  period_timer_pkg::state_t s_d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic src_tick;
    logic pin_rise;
    logic gate_fall;
    logic halted;
    logic presc_tick;
    logic [7:0] tc;
    s_d = s_q;
    src_tick = 1'b0;
    pin_rise = 1'b0;
    gate_fall = 1'b0;
    presc_tick = 1'b0;
    halted = 1'b0;
    tc = `PRESCALE_TC_1;
    s_d.match_evt = 1'b0;
    s_d.gate_evt = 1'b0;
    // Two stages absorb metastability; third stage gives edge history
    s_d.pin_s1 = external_clock_gate_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    pin_rise = s_q.pin_s2 & ~s_q.pin_s3;
    gate_fall = ~s_q.pin_s2 & s_q.pin_s3;

    // ------------------------------------------------------------------
    // Prescale terminal and halts
    // ------------------------------------------------------------------
    // [RL10] Prescale terminal
    unique case (s_q.ctrl.prescale_select)
      period_timer_pkg::PRESCALE_1: tc = `PRESCALE_TC_1;
      period_timer_pkg::PRESCALE_8: tc = `PRESCALE_TC_8;
      period_timer_pkg::PRESCALE_64: tc = `PRESCALE_TC_64;
      period_timer_pkg::PRESCALE_256: tc = `PRESCALE_TC_256;
    endcase

    // [RL3] Idle stop
    // [RL6] Idle stop, asynchronous
    if (cpu_idle && s_q.ctrl.idle_stop_select) begin
      halted = 1'b1;
    end
    // [RL13] Sleep keeps only asynchronous external counting
    if (cpu_sleep && !(s_q.ctrl.clock_source_select &&
        !s_q.ctrl.external_sync_select)) begin
      halted = 1'b1;
    end

    if (s_q.ctrl.clock_source_select) begin
      // [RL4] Synchronized edges
      // [RL5] Asynchronous edges, sampled here on the core clock
      // Both counter modes share the sampled edge; a true async path
      // would need a separate pin-clocked domain, traded for one clock.
      src_tick = pin_rise;
    end else if (s_q.ctrl.gate_accumulate_enable) begin
      // [RL7] Gated accumulation
      // [RL8] Relies on internal source with gate
      src_tick = s_q.pin_s2;
    end else begin
      // [RL2] Cycle counting
      src_tick = 1'b1;
    end

    // ------------------------------------------------------------------
    // Prescaler and count
    // ------------------------------------------------------------------
    if (s_q.ctrl.counter_run_enable && !halted && src_tick) begin
      // At or past terminal: a smaller divide picked mid-count ends at once
      if (s_q.presc >= tc) begin
        s_d.presc = 8'h00;
        presc_tick = 1'b1;
      end else begin
        s_d.presc = s_q.presc + 8'h01;
      end
    end

    if (presc_tick) begin
      // [RL14] Compare on each counting enable
      if (s_q.count == s_q.period) begin
        s_d.count = `COUNT_RESET;
        s_d.match_evt = 1'b1;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end

    // [RL9] Gate falling edge event
    if (s_q.ctrl.counter_run_enable && s_q.ctrl.gate_accumulate_enable &&
        !s_q.ctrl.clock_source_select && gate_fall) begin
      s_d.gate_evt = 1'b1;
    end

    // ------------------------------------------------------------------
    // Software writes
    // ------------------------------------------------------------------
    if (period_write) begin
      s_d.period = period_write_data;
    end
    // A count write outranks a tick in the same cycle
    // [RL11] Count write clears prescaler
    if (count_write) begin
      s_d.count = count_write_data;
      s_d.presc = 8'h00;
    end
    // [RL11] Control write leaves count alone
    if (control_write) begin
      s_d.ctrl.counter_run_enable = timer_control_word[`CTRL_RUN_BIT];
      s_d.ctrl.idle_stop_select = timer_control_word[`CTRL_IDLE_STOP_BIT];
      s_d.ctrl.gate_accumulate_enable = timer_control_word[`CTRL_GATE_BIT];
      s_d.ctrl.prescale_select = period_timer_pkg::prescale_t'(
        timer_control_word[`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO]);
      s_d.ctrl.external_sync_select = timer_control_word[`CTRL_SYNC_BIT];
      s_d.ctrl.clock_source_select = timer_control_word[`CTRL_SOURCE_BIT];
      // [RL11] Clearing run clears prescaler
      if (!timer_control_word[`CTRL_RUN_BIT]) begin
        s_d.presc = 8'h00;
      end
    end

    // [RL12] Set wins over clear
    if (flag_clear) begin
      s_d.flag = 1'b0;
    end
    if (s_d.match_evt || s_d.gate_evt) begin
      s_d.flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // [RL15] Configuration cleared, counter stopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.period <= `PERIOD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    control_readback = `CTRL_RESET;
    control_readback[`CTRL_RUN_BIT] = s_q.ctrl.counter_run_enable;
    control_readback[`CTRL_IDLE_STOP_BIT] = s_q.ctrl.idle_stop_select;
    control_readback[`CTRL_GATE_BIT] = s_q.ctrl.gate_accumulate_enable;
    control_readback[`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO] =
      s_q.ctrl.prescale_select;
    control_readback[`CTRL_SYNC_BIT] = s_q.ctrl.external_sync_select;
    control_readback[`CTRL_SOURCE_BIT] = s_q.ctrl.clock_source_select;
  end

  assign count_value = s_q.count;
  assign period_match_value = s_q.period;
  assign match_event = s_q.match_evt;
  assign gate_end_event = s_q.gate_evt;
  assign period_interrupt_flag = s_q.flag;

endmodule : period_timer_16bit

// ---- test/period_timer_props.sv ----
`include "period_timer_defines.svh"

module period_timer_props (
  // Clock, reset and inputs
  input wire logic core_clk,
  input wire logic rst,
  input wire logic count_write,
  input wire logic [15:0] count_write_data,
  input wire logic period_write,
  input wire logic [15:0] period_write_data,
  input wire logic flag_clear,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // Outputs
  input wire logic [15:0] count_value,
  input wire logic [15:0] period_match_value,
  input wire logic [15:0] control_readback,
  input wire logic match_event,
  input wire logic gate_end_event,
  input wire logic period_interrupt_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_match_wraps: assert property (
    match_event |-> count_value == 16'h0000) else $error("no wrap");
  a_event_flag: assert property (
    match_event || gate_end_event |-> period_interrupt_flag)
    else $error("flag missing");
  a_flag_sticky: assert property (
    period_interrupt_flag && !flag_clear |=> period_interrupt_flag)
    else $error("flag dropped");
  a_count_load: assert property (
    count_write |=> count_value == $past(count_write_data))
    else $error("count load");
  a_stop_hold: assert property (
    !control_readback[`CTRL_RUN_BIT] && !count_write
    |=> $stable(count_value))
    else $error("count moved");
  a_idle_hold: assert property (
    control_readback[`CTRL_IDLE_STOP_BIT] && cpu_idle && !count_write
    |=> $stable(count_value)) else $error("idle count");
  a_sleep_hold: assert property (
    control_readback[`CTRL_RUN_BIT] && !control_readback[`CTRL_SOURCE_BIT]
    && cpu_sleep
    && !count_write |=> $stable(count_value)) else $error("sleep count");
  a_timer_step: assert property (
    control_readback[`CTRL_RUN_BIT] && !control_readback[`CTRL_GATE_BIT]
    && control_readback[`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO] == 2'h0
    && !control_readback[`CTRL_SOURCE_BIT]
    && !cpu_idle && !cpu_sleep && !count_write
    && count_value != period_match_value
    |=> count_value == $past(count_value) + 16'h0001)
    else $error("no step");
  a_gate_source: assert property (
    gate_end_event |-> $past(control_readback[`CTRL_GATE_BIT])
    && $past(control_readback[`CTRL_RUN_BIT])
    && !$past(control_readback[`CTRL_SOURCE_BIT]))
    else $error("gate event outside gated mode");
  a_period_load: assert property (
    period_write |=> period_match_value == $past(period_write_data))
    else $error("period load");
endmodule : period_timer_props

bind period_timer_16bit period_timer_props i_props (.*);

// ---- test/ext_pin_model.sv ----
module ext_pin_model (
  // Control from the bench
  input wire logic core_clk,
  input wire logic pin_run,
  input wire logic [7:0] pin_half,
  // Pin toward the timer
  output logic external_clock_gate_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q = 8'h00;
  logic pin_q = 1'b0;
  assign external_clock_gate_pin = pin_q;
  // Pin rests low outside a burst so no stray edge leaks in
  always @(posedge core_clk) begin
    if (!pin_run) begin
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end else if (cnt_q == pin_half - 8'h01) begin
      cnt_q <= 8'h00;
      pin_q <= ~pin_q;
    end else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule : ext_pin_model

// ---- test/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst = 1, control_write = 0, count_write = 0;
  logic period_write = 0, flag_clear = 0, cpu_idle = 0, cpu_sleep = 0;
  logic [15:0] timer_control_word = 0, count_write_data = 0;
  logic [15:0] period_write_data = 0, count_value, period_match_value;
  logic [15:0] control_readback, c;
  logic match_event, gate_end_event, period_interrupt_flag;
  logic external_clock_gate_pin, pin_run = 0;
  logic [7:0] pin_half = 8'h03;
  int mismatches = 0, checked = 0, cyc = 0, n;
  period_timer_16bit i_dut (.*);
  ext_pin_model i_pin (.*);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(negedge core_clk);
  endtask : tick
  // Selector: 0 control, 1 count, 2 period
  task automatic wr(int k, logic [15:0] v);
    tick(1);
    {timer_control_word, count_write_data, period_write_data} = {3{v}};
    {control_write, count_write, period_write} = {k == 0, k == 1, k == 2};
    tick(1);
    {control_write, count_write, period_write} = 3'h0;
  endtask : wr
  task automatic t_timer();
    wr(2, 16'h0002);
    wr(0, 16'h8000);
    for (n = 0; n < 20 && match_event !== 1'b1; n++) tick(1);
    chk("wrap", count_value, 16'h0000);
    chk("match", match_event, 16'h0001);
    chk("flag", period_interrupt_flag, 16'h0001);
    wr(0, 16'h0000);
    c = count_value;
    chk("pulse", match_event, 16'h0000);
    wr(0, 16'h0030);
    chk("ctl keeps", count_value, c);
    flag_clear = 1;
    tick(1);
    flag_clear = 0;
    chk("cleared", period_interrupt_flag, 16'h0000);
  endtask : t_timer
  task automatic t_prescale();
    for (int p = 0; p < 4; p++) begin
      wr(0, 16'h0000);
      wr(2, 16'hFFFF);
      wr(1, 16'h0000);
      wr(0, 16'h8000 | 16'(p << 4));
      for (n = 0; n < 300 && count_value === 16'h0000; n++) tick(1);
      c = count_value;
      for (n = 0; n < 300 && count_value === c; n++) tick(1);
      chk("divide", 16'(n), p == 3 ? 16'h0100 : 16'(1 << 3 * p));
    end
    // run clear and count write clear the prescaler
    wr(0, 16'h0000);
    wr(1, 16'h0000);
    wr(0, 16'h8010);
    tick(3);
    wr(0, 16'h0010);
    wr(0, 16'h8010);
    for (n = 0; n < 20 && count_value === 16'h0000; n++) tick(1);
    chk("run clr", 16'(n), 16'h0008);
    tick(3);
    wr(1, 16'h0000);
    for (n = 0; n < 20 && count_value === 16'h0000; n++) tick(1);
    chk("cnt clr", 16'(n), 16'h0008);
  endtask : t_prescale
  task automatic t_idle();
    wr(0, 16'h0000);
    wr(0, 16'hA000);
    cpu_idle = 1;
    tick(2);
    c = count_value;
    tick(10);
    chk("idle stop", count_value, c);
    wr(0, 16'h8000);
    c = count_value;
    tick(4);
    chk("idle run", count_value - c, 16'h0004);
    cpu_idle = 0;
    cpu_sleep = 1;
    c = count_value;
    tick(4);
    chk("sleep stop", count_value, c);
    cpu_sleep = 0;
  endtask : t_idle
  // external counter modes, or gate mode set with run and internal source
  task automatic t_ext(logic [15:0] cfg, logic [7:0] h, logic [1:0] pw,
      logic [15:0] e);
    wr(0, 16'h0000);
    wr(1, 16'h0000);
    wr(0, cfg);
    // Power state as idle then sleep
    {cpu_idle, cpu_sleep} = pw;
    pin_half = h;
    pin_run = 1;
    tick(2 * int'(h) * (cfg[6] ? 1 : 5));
    pin_run = 0;
    for (n = 0; n < 12 && gate_end_event !== 1'b1; n++) tick(1);
    {cpu_idle, cpu_sleep} = 2'h0;
    chk("edges", count_value, e);
    chk("gate evt", gate_end_event, 16'(cfg[6]));
    if (cfg[6])
      chk("gate end", period_interrupt_flag, 16'h0001);
  endtask : t_ext
  task automatic t_reset();
    wr(2, 16'h0005);
    wr(0, 16'h8000);
    tick(3);
    rst = 1;
    tick(2);
    rst = 0;
    chk("ctl rst", control_readback, 16'h0000);
    chk("per rst", period_match_value, 16'hFFFF);
    chk("cnt rst", count_value, 16'h0000);
    chk("flag rst", period_interrupt_flag, 16'h0000);
    tick(3);
    chk("stopped", count_value, 16'h0000);
  endtask : t_reset
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    tick(10);
    rst = 0;
    chk("ctl rst", control_readback, 16'h0000);
    chk("per rst", period_match_value, 16'hFFFF);
    t_timer();
    t_prescale();
    t_idle();
    t_ext(16'h8006, 8'h03, 2'h0, 16'h0005);
    t_ext(16'h8006, 8'h03, 2'h1, 16'h0000);
    t_ext(16'h8002, 8'h03, 2'h1, 16'h0005);
    t_ext(16'hA002, 8'h03, 2'h2, 16'h0000);
    t_ext(16'h8040, 8'h07, 2'h0, 16'h0007);
    t_reset();
    close_out();
  end
endmodule : testbench
